/* File: verilog/bscp_pkg.sv */
// Package: constants and pad permutation for the strap and pin-order block.
package bscp_pkg;
    localparam int NPAD = 30;
    localparam int NSYNC = 42;
    // Logical parallel ATA signal indices; the index equals the pad in normal order.
    localparam int LI_DD0 = 0;
    localparam int LI_DD15 = 15;
    localparam int LI_CS0 = 16;
    localparam int LI_CS1 = 17;
    localparam int LI_DA0 = 18;
    localparam int LI_DA2 = 20;
    localparam int LI_DIOR = 21;
    localparam int LI_DIOW = 22;
    localparam int LI_DMACK = 23;
    localparam int LI_DMARQ = 24;
    localparam int LI_INTRQ = 25;
    localparam int LI_IORDY = 26;
    localparam int LI_RESET = 27;
    localparam int LI_DASP = 28;
    localparam int LI_SP = 29;
    // Positions in the synchroniser vector above the pads.
    localparam int SY_SSC = 30;
    localparam int SY_CLK0 = 31;
    localparam int SY_MODE0 = 33;
    localparam int SY_MODE2 = 35;
    localparam int SY_FIX = 36;
    localparam int SY_OE = 37;
    localparam int SY_PM = 38;
    localparam int SY_MS = 39;
    localparam int SY_PDIAG = 40;
    localparam int SY_POR = 41;
    // Reset value of the synchronisers: pulls as fitted, power-on reset idle.
    localparam logic [41:0] SYNC_RST = 42'h264_8000_0000;
    localparam logic [2:0] SETTLE_CNT = 3'h5;
    localparam logic [1:0] CLKSEL_25M = 2'h1;
    localparam logic [1:0] RATE_RSVD = 2'h3;
    localparam logic [1:0] RATE_100 = 2'h0;
    localparam logic [1:0] RATE_133 = 2'h1;
    localparam logic [2:0] UDMA_100 = 3'h5;
    localparam logic [2:0] UDMA_133 = 3'h6;
    localparam logic [2:0] UDMA_150 = 3'h7;
    localparam logic [2:0] UDMA_RST = 3'h0;
    localparam logic [2:0] PIO_IORDY_MIN = 3'h3;
    // Register byte offsets and field positions.
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STRAP = 8'h04;
    localparam logic [7:0] REG_STAT = 8'h08;
    localparam int CT_FLOAT = 0;
    localparam int CT_PMBLK = 1;
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam int SR_UDMA = 8;

    typedef enum logic [0:0] {
        BSCP_DEV_BRIDGE = 1'b0,
        BSCP_HOST_BRIDGE = 1'b1
    } bscp_role_t;

    // Reverse pin order is an involution, so one table maps both ways.
    function automatic logic [4:0] rev_map(input logic [4:0] i);
        logic [4:0] r;
        r = i;
        case (i)
            5'h00: r = 5'h0d;
            5'h01: r = 5'h0e;
            5'h02: r = 5'h0f;
            5'h03: r = 5'h16;
            5'h04: r = 5'h17;
            5'h05: r = 5'h1d;
            5'h06: r = 5'h12;
            5'h07: r = 5'h10;
            5'h08: r = 5'h14;
            5'h09: r = 5'h13;
            5'h0a: r = 5'h19;
            5'h0b: r = 5'h15;
            5'h0c: r = 5'h18;
            5'h0d: r = 5'h00;
            5'h0e: r = 5'h01;
            5'h0f: r = 5'h02;
            5'h10: r = 5'h07;
            5'h11: r = 5'h1b;
            5'h12: r = 5'h06;
            5'h13: r = 5'h09;
            5'h14: r = 5'h08;
            5'h15: r = 5'h0b;
            5'h16: r = 5'h03;
            5'h17: r = 5'h04;
            5'h18: r = 5'h0c;
            5'h19: r = 5'h0a;
            5'h1b: r = 5'h11;
            5'h1d: r = 5'h05;
            default: r = i;
        endcase
        return r;
    endfunction
endpackage

/* File: verilog/bscp_pinmux.sv */
// Strap capture, configuration decode and parallel ATA pin-function multiplexer.
`timescale 1ns/1ps
`default_nettype none

// Function
// - Spread-spectrum clocking off when its strap is low, on when high.
// - Reference clock select must be 01; anything else is flagged reserved.
// - Link-up status low until the serial link is established, then high.
// - Top mode strap bit 0 selects device bridge, 1 selects host bridge.
// - Fixed rate uses low mode bits: 00 100MB/s, 01 133MB/s, 10 150MB/s.
// - Fixed-rate strap 0 takes rate from SET FEATURES; 1 ignores that command.
// - Output-enable strap 0 floats every parallel ATA pad; the master/slave and diagnostic strap pins are not gated by it.
// - Slumber translation of power commands only when its strap is 1.
// - Power-on reset low resets all logic except the synchronisers and settle count, which rst_i alone resets, and the strap register, which loads the pins.
// - Host bridge: master/slave strap picks device 0 or 1; else reserved output.
// - Device 0 reads the activity pin; device 1 drives it low for presence.
// - Host bridge: slave-present is an input as device 0, output as device 1.
// - Device bridge: slave-present is cable detect, 0 means 80-conductor.
// - Host bridge: diagnostic pin carries device 1 diagnosis done to device 0.
// - Device bridge: diagnostic pin is sampled as the pin-order strap.
// - Reverse order remaps signals by a fixed pad permutation.
// - Device side lengthens PIO cycles with IORDY from PIO mode 3 upward.
// - Device side drives DDMARDY and DSTROBE on the IORDY pin.
// - Device requests DMA on DMARQ high; host acknowledges on DMACK low.
// - With translation strap low no Partial or Slumber request is taken or made.
module bscp_pinmux (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic power_on_reset_n_i,
    input wire logic spread_clock_enable_strap_i,
    input wire logic [1:0] ref_clock_select_strap_i,
    input wire logic [2:0] mode_strap_i,
    input wire logic fixed_udma_rate_strap_i,
    input wire logic parallel_output_enable_strap_i,
    input wire logic slumber_translate_enable_strap_i,
    input wire logic master_slave_strap_i,
    output logic master_slave_strap_o,
    output logic master_slave_strap_oe_o,
    input wire logic pin_order_reverse_strap_i,
    output logic pin_order_reverse_strap_o,
    output logic pin_order_reverse_strap_oe_o,
    input wire logic [29:0] pad_i,
    output logic [29:0] pad_o,
    output logic [29:0] pad_oe_o,
    input wire logic [29:0] core_out_i,
    output logic [29:0] core_in_o,
    input wire logic core_dd_drive_i,
    input wire logic [2:0] core_pio_mode_i,
    input wire logic core_udma_active_i,
    input wire logic core_diag_busy_i,
    input wire logic core_activity_i,
    input wire logic core_diag_done_i,
    input wire logic setfeat_valid_i,
    input wire logic [2:0] setfeat_mode_i,
    input wire logic phy_ready_i,
    input wire logic pm_cmd_done_i,
    input wire logic link_pm_req_i,
    output logic global_reset_o,
    output logic spread_clock_enable_o,
    output logic link_up_status_o,
    output logic host_bridge_o,
    output logic device1_o,
    output logic cable_80_o,
    output logic diag_seen_o,
    output logic cfg_fault_o,
    output logic [2:0] udma_mode_o,
    output logic slumber_req_o,
    output logic pm_accept_o,
    output logic pm_reject_o
);
    logic [41:0] s1_ff;
    logic [41:0] s2_ff;
    logic [41:0] s3_ff;
    logic [41:0] filt_ff;
    logic [41:0] nxt_filt;
    logic [10:0] strap_ff;
    logic [2:0] settle_ff;
    logic srst;
    logic cap;
    logic [1:0] ctrl_ff;
    logic [2:0] udma_ff;
    logic link_ff;
    logic ssc_ff;
    logic ack_ff;
    logic [31:0] rdat_ff;
    logic [29:0] pad_o_ff;
    logic [29:0] pad_oe_ff;
    logic [29:0] out_log;
    logic [29:0] oe_log;
    logic [29:0] in_log;
    logic ms_o_ff;
    logic ms_oe_ff;
    logic pd_oe_ff;
    logic slumber_ff;
    logic accept_ff;
    logic reject_ff;
    logic pm_en;
    logic host;
    logic dev1;
    logic rev;
    logic pads_on;
    logic [2:0] fix_udma;
    logic req;
    logic [31:0] stat_w;

    // The synchroniser stages are cleared by rst_i only, so that a held
    // power-on reset still reaches the filter below.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_ff <= bscp_pkg::SYNC_RST;
            s2_ff <= bscp_pkg::SYNC_RST;
            s3_ff <= bscp_pkg::SYNC_RST;
            filt_ff <= bscp_pkg::SYNC_RST;
        end else begin
            s1_ff <= {power_on_reset_n_i, pin_order_reverse_strap_i, master_slave_strap_i,
                      slumber_translate_enable_strap_i, parallel_output_enable_strap_i,
                      fixed_udma_rate_strap_i, mode_strap_i, ref_clock_select_strap_i,
                      spread_clock_enable_strap_i, pad_i};
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            filt_ff <= nxt_filt;
        end
    end

    // A bit moves only once the second and third stages agree.
    assign nxt_filt = (s2_ff & ~(s2_ff ^ s3_ff)) | (filt_ff & (s2_ff ^ s3_ff));

    assign srst = rst_i | ~filt_ff[bscp_pkg::SY_POR];
    assign global_reset_o = srst;

    // After rst_i alone the filter needs a few cycles before its value is real.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            settle_ff <= bscp_pkg::SETTLE_CNT;
        end else if (settle_ff != 3'h0) begin
            settle_ff <= settle_ff - 3'h1;
        end
    end

    assign cap = srst | (settle_ff != 3'h0);

    // Straps load throughout reset and are frozen afterwards, so a pin that
    // later turns into an output cannot disturb the configuration.
    always_ff @(posedge clk_i) begin
        if (cap) begin
            strap_ff <= filt_ff[bscp_pkg::SY_PDIAG:bscp_pkg::SY_SSC];
        end
    end

    assign host = strap_ff[bscp_pkg::SY_MODE2 - 30] == bscp_pkg::BSCP_HOST_BRIDGE;
    assign dev1 = host & strap_ff[bscp_pkg::SY_MS - 30];
    assign rev = ~host & strap_ff[bscp_pkg::SY_PDIAG - 30];
    assign pm_en = strap_ff[bscp_pkg::SY_PM - 30] & ~ctrl_ff[bscp_pkg::CT_PMBLK];
    assign pads_on = strap_ff[bscp_pkg::SY_OE - 30] & ~ctrl_ff[bscp_pkg::CT_FLOAT];

    always_comb begin
        case (strap_ff[bscp_pkg::SY_MODE0 - 29:bscp_pkg::SY_MODE0 - 30])
            bscp_pkg::RATE_100: fix_udma = bscp_pkg::UDMA_100;
            bscp_pkg::RATE_133: fix_udma = bscp_pkg::UDMA_133;
            default: fix_udma = bscp_pkg::UDMA_150;
        endcase
    end

    // Fixed rate wins over any SET FEATURES seen in the same cycle.
    always_ff @(posedge clk_i) begin
        if (srst) begin
            udma_ff <= bscp_pkg::UDMA_RST;
        end else if (strap_ff[bscp_pkg::SY_FIX - 30]) begin
            udma_ff <= fix_udma;
        end else if (setfeat_valid_i) begin
            udma_ff <= setfeat_mode_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst) begin
            link_ff <= 1'b0;
            ssc_ff <= 1'b0;
        end else begin
            link_ff <= phy_ready_i;
            ssc_ff <= strap_ff[bscp_pkg::SY_SSC - 30];
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst) begin
            slumber_ff <= 1'b0;
            accept_ff <= 1'b0;
            reject_ff <= 1'b0;
        end else begin
            slumber_ff <= pm_en & pm_cmd_done_i;
            accept_ff <= pm_en & link_pm_req_i;
            reject_ff <= ~pm_en & link_pm_req_i;
        end
    end

    // Logical direction and value of each parallel ATA signal.
    always_comb begin
        out_log = core_out_i;
        oe_log = '0;
        oe_log[bscp_pkg::LI_DD15:bscp_pkg::LI_DD0] = {16{core_dd_drive_i}};
        if (host) begin
            oe_log[bscp_pkg::LI_DMARQ] = 1'b1;
            oe_log[bscp_pkg::LI_INTRQ] = 1'b1;
            oe_log[bscp_pkg::LI_IORDY] = (core_pio_mode_i >= bscp_pkg::PIO_IORDY_MIN)
                                         | core_udma_active_i;
            out_log[bscp_pkg::LI_DASP] = 1'b0;
            oe_log[bscp_pkg::LI_DASP] = dev1 & (core_diag_busy_i | core_activity_i);
            out_log[bscp_pkg::LI_SP] = 1'b1;
            oe_log[bscp_pkg::LI_SP] = dev1;
        end else begin
            oe_log[bscp_pkg::LI_DA2:bscp_pkg::LI_CS0] = 5'h1f;
            oe_log[bscp_pkg::LI_DIOR] = 1'b1;
            oe_log[bscp_pkg::LI_DIOW] = 1'b1;
            oe_log[bscp_pkg::LI_DMACK] = 1'b1;
            oe_log[bscp_pkg::LI_RESET] = 1'b1;
            out_log[bscp_pkg::LI_DASP] = 1'b1;
            oe_log[bscp_pkg::LI_DASP] = 1'b1;
        end
    end

    // Pads are registered so that every pin changes on a clock edge together
    // with its enable; the cost is one cycle of latency on outputs.
    always_ff @(posedge clk_i) begin
        if (srst) begin
            pad_o_ff <= '0;
            pad_oe_ff <= '0;
        end else begin
            for (int p = 0; p < bscp_pkg::NPAD; p++) begin
                if (rev) begin
                    pad_o_ff[p] <= out_log[bscp_pkg::rev_map(5'(p))];
                    pad_oe_ff[p] <= oe_log[bscp_pkg::rev_map(5'(p))] & pads_on;
                end else begin
                    pad_o_ff[p] <= out_log[p];
                    pad_oe_ff[p] <= oe_log[p] & pads_on;
                end
            end
        end
    end

    always_comb begin
        for (int l = 0; l < bscp_pkg::NPAD; l++) begin
            in_log[l] = rev ? filt_ff[bscp_pkg::rev_map(5'(l))] : filt_ff[l];
        end
    end

    assign core_in_o = in_log;
    assign pad_o = pad_o_ff;
    assign pad_oe_o = pad_oe_ff;

    // Strap pins that turn into outputs after configuration.
    // Neither pin is driven while capture is still open: the synchronisers
    // lag the pin by several cycles, so an early drive would be read back
    // as the strap itself and overwrite what the board set.
    always_ff @(posedge clk_i) begin
        if (srst) begin
            ms_o_ff <= 1'b0;
            ms_oe_ff <= 1'b0;
            pd_oe_ff <= 1'b0;
        end else begin
            ms_o_ff <= 1'b0;
            ms_oe_ff <= ~host & ~cap;
            pd_oe_ff <= dev1 & core_diag_done_i & ~cap;
        end
    end

    assign master_slave_strap_o = ms_o_ff;
    assign master_slave_strap_oe_o = ms_oe_ff;
    assign pin_order_reverse_strap_o = 1'b0;
    assign pin_order_reverse_strap_oe_o = pd_oe_ff;

    assign spread_clock_enable_o = ssc_ff;
    assign link_up_status_o = link_ff;
    assign host_bridge_o = host;
    assign device1_o = dev1;
    assign cable_80_o = host | ~in_log[bscp_pkg::LI_SP];
    assign diag_seen_o = host & ~dev1 & ~filt_ff[bscp_pkg::SY_PDIAG];
    assign cfg_fault_o = (strap_ff[2:1] != bscp_pkg::CLKSEL_25M)
                         | (strap_ff[4:3] == bscp_pkg::RATE_RSVD);
    assign udma_mode_o = udma_ff;
    assign slumber_req_o = slumber_ff;
    assign pm_accept_o = accept_ff;
    assign pm_reject_o = reject_ff;

    // Wishbone classic slave: one wait state, writes land on the ack edge.
    assign req = wb_cyc_i & wb_stb_i;
    assign stat_w = {21'h0, udma_ff, 1'b0, dev1, host,
                     strap_ff[4:3] == bscp_pkg::RATE_RSVD,
                     strap_ff[2:1] != bscp_pkg::CLKSEL_25M,
                     diag_seen_o, cable_80_o, link_ff};

    always_ff @(posedge clk_i) begin
        if (srst) begin
            ack_ff <= 1'b0;
            rdat_ff <= '0;
        end else begin
            ack_ff <= req & ~ack_ff;
            if (req & ~ack_ff) begin
                case (wb_adr_i)
                    bscp_pkg::REG_CTRL: rdat_ff <= {30'h0, ctrl_ff};
                    bscp_pkg::REG_STRAP: rdat_ff <= {21'h0, strap_ff};
                    bscp_pkg::REG_STAT: rdat_ff <= stat_w;
                    default: rdat_ff <= '0;
                endcase
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst) begin
            ctrl_ff <= bscp_pkg::CTRL_RST;
        end else if (req & ack_ff & wb_we_i & wb_sel_i[0] & (wb_adr_i == bscp_pkg::REG_CTRL)) begin
            ctrl_ff <= wb_dat_i[1:0];
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdat_ff;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (srst);

    strap_hold_a: assert property (!cap ##1 !cap |-> $stable(strap_ff))
        else $error("strap changed after capture");
    ssc_out_a: assert property (##1 spread_clock_enable_o == $past(strap_ff[0]))
        else $error("spread clock enable does not follow strap");
    link_up_a: assert property (phy_ready_i ##1 phy_ready_i |-> link_up_status_o)
        else $error("link up not shown");
    link_down_a: assert property (!phy_ready_i |=> !link_up_status_o)
        else $error("link up shown without link");
    strap_quiet_a: assert property (cap |=> !master_slave_strap_oe_o && !pin_order_reverse_strap_oe_o)
        else $error("strap pin driven during capture");
    rate_fix_a: assert property (strap_ff[6] && strap_ff[4:3] == 2'h2 && $stable(strap_ff)
                                 |=> udma_mode_o == 3'h7)
        else $error("fixed rate 150 not applied");
    setfeat_ign_a: assert property (strap_ff[6] && setfeat_valid_i && $stable(strap_ff)
                                    |=> udma_mode_o == $past(fix_udma))
        else $error("set features altered fixed rate");
    setfeat_take_a: assert property (!strap_ff[6] && setfeat_valid_i
                                     |=> udma_mode_o == $past(setfeat_mode_i))
        else $error("set features rate not taken");
    ata_float_a: assert property (!strap_ff[7] && $stable(strap_ff) |=> pad_oe_o == 30'h0)
        else $error("ata pins driven while disabled");
    pm_block_a: assert property (!strap_ff[8] ##1 !strap_ff[8]
                                 |-> !slumber_req_o && !pm_accept_o)
        else $error("power management acted while disabled");
    dasp_in_a: assert property (host && !dev1 && $stable(strap_ff) |=> !pad_oe_o[28])
        else $error("device 0 drives activity pin");
    rev_map_a: assert property (rev && pads_on && $stable(strap_ff) && $stable(ctrl_ff)
                                |=> pad_o[0] == $past(out_log[13]))
        else $error("reverse order mapping wrong");
    wb_ack_a: assert property (req && !ack_ff |=> ack_ff ##1 !ack_ff)
        else $error("bus ack timing wrong");

    host_dev1_c: cover property (host && dev1 && pad_oe_o[29]);
    reverse_c: cover property (rev && pads_on);
    setfeat_c: cover property (!strap_ff[6] && setfeat_valid_i);
    iordy_ext_c: cover property (host && !rev && pad_oe_o[26]);
    slumber_c: cover property (slumber_req_o);
endmodule

`default_nettype wire

/* File: tb/bscp_ide_model.sv */
// Behavioural model of the parallel ATA party that faces the pads.
`timescale 1ns/1ps
`default_nettype none
module bscp_ide_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [29:0] pad_o_i,
    input wire logic [29:0] pad_oe_i,
    input wire logic [29:0] drv_i,
    input wire logic [29:0] val_i,
    output logic [29:0] pad_o
);
    logic [29:0] last_ff;
    logic [29:0] rel;
    // A released line shows the inverse of its last level, except 28 (high) and 29 (low), so a stale value never passes for a driven one.
    always_comb begin
        rel = ~last_ff;
        rel[28] = 1'b1;
        rel[29] = 1'b0;
    end
    // The host holds its strobes and acknowledge at the idle level unless told otherwise.
    assign pad_o = (pad_oe_i & pad_o_i) | (~pad_oe_i & drv_i & val_i) | (~pad_oe_i & ~drv_i & rel);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            last_ff <= 30'h0;
        end else begin
            last_ff <= pad_o;
        end
    end
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking testbench for the strap decode and pin-order block.
`timescale 1ns/1ps
`default_nettype none
module tb;
    typedef struct packed {
        logic ssc; logic [1:0] cks; logic [2:0] mode; logic fix; logic ms;
        logic [2:0] udma; logic host; logic dev1; logic flt;
    } bscp_row_t;
    logic clk, rst, cyc, stb, we, ack, por_n, ssc, fix, oe, pm, ms_drv, po_drv, dd, sfv, phy, pmd, lpr, ddone;
    logic mso, msoe, poo, pooe, grst, ssco, lnk, host, dev1, c80, dseen, flt, slq, pacc, prej;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [1:0] cks;
    logic [2:0] mode, sfm, udma, pio;
    logic uda, dbsy, act;
    logic [31:0] wdat, rdat, q;
    logic [29:0] pin, pout, poe, cout, cin, hdrv, hval;
    int fails, n_tests;
    wire logic ms_w = msoe ? mso : ms_drv;
    wire logic po_w = pooe ? poo : po_drv;
    // Mode 11 is never presented: the board must give the low mode bits a legal level.
    bscp_row_t rows [5] = '{
        '{1'b0, 2'h1, 3'h0, 1'b1, 1'b0, 3'h5, 1'b0, 1'b0, 1'b0},
        '{1'b1, 2'h1, 3'h1, 1'b1, 1'b0, 3'h6, 1'b0, 1'b0, 1'b0},
        '{1'b0, 2'h1, 3'h6, 1'b1, 1'b1, 3'h7, 1'b1, 1'b1, 1'b0},
        '{1'b0, 2'h2, 3'h6, 1'b1, 1'b0, 3'h7, 1'b1, 1'b0, 1'b1},
        '{1'b0, 2'h1, 3'h5, 1'b0, 1'b1, 3'h0, 1'b1, 1'b1, 1'b0}};

    bscp_pinmux bscp_pinmux_i (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .power_on_reset_n_i(por_n), .spread_clock_enable_strap_i(ssc), .ref_clock_select_strap_i(cks),
        .mode_strap_i(mode), .fixed_udma_rate_strap_i(fix), .parallel_output_enable_strap_i(oe),
        .slumber_translate_enable_strap_i(pm), .master_slave_strap_i(ms_w), .master_slave_strap_o(mso),
        .master_slave_strap_oe_o(msoe), .pin_order_reverse_strap_i(po_w), .pin_order_reverse_strap_o(poo),
        .pin_order_reverse_strap_oe_o(pooe), .pad_i(pin), .pad_o(pout), .pad_oe_o(poe), .core_out_i(cout),
        .core_in_o(cin), .core_dd_drive_i(dd), .core_pio_mode_i(pio), .core_udma_active_i(uda),
        .core_diag_busy_i(dbsy), .core_activity_i(act), .core_diag_done_i(ddone), .setfeat_valid_i(sfv),
        .setfeat_mode_i(sfm), .phy_ready_i(phy), .pm_cmd_done_i(pmd), .link_pm_req_i(lpr),
        .global_reset_o(grst), .spread_clock_enable_o(ssco), .link_up_status_o(lnk), .host_bridge_o(host),
        .device1_o(dev1), .cable_80_o(c80), .diag_seen_o(dseen), .cfg_fault_o(flt), .udma_mode_o(udma),
        .slumber_req_o(slq), .pm_accept_o(pacc), .pm_reject_o(prej));

    bscp_ide_model bscp_ide_model_i (.clk_i(clk), .rst_i(rst), .pad_o_i(pout), .pad_oe_i(poe),
        .drv_i(hdrv), .val_i(hval), .pad_o(pin));

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
            fails++;
        end
    endtask

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // Classic single cycle: hold the request until ack is sampled high, then idle one cycle.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, 4'hf};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat;
        if (n >= 20) fails++;
        {cyc, stb} <= 2'b00;
        @(posedge clk);
    endtask

    // Straps only load around reset, so every configuration needs a fresh reset.
    task automatic do_rst;
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (12) @(posedge clk);
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        test_done();
    end

    initial begin
        {rst, cyc, stb, we, ssc, fix, ms_drv, po_drv, dd, sfv, phy, pmd, lpr, ddone} = 14'h0;
        {por_n, oe, pm} = 3'h7;
        {adr, sel, wdat, sfm, cout} = '0;
        {pio, uda, dbsy, act} = 6'h02;
        cks = 2'h1;
        mode = 3'h2;
        hdrv = 30'h08e0_0000;
        hval = hdrv;
        fails = 0;
        n_tests = 0;
        for (int i = 0; i < 5; i++) begin
            {ssc, cks, mode, fix, ms_drv} <= {rows[i].ssc, rows[i].cks, rows[i].mode, rows[i].fix, rows[i].ms};
            do_rst();
            chk("ssc", ssco, rows[i].ssc);
            chk("udma", udma, rows[i].udma);
            chk("host", host, rows[i].host);
            chk("dev1", dev1, rows[i].dev1);
            chk("fault", flt, rows[i].flt);
            chk("ms_oe", msoe, !rows[i].host);
            chk("dasp", {poe[28], pout[28]}, {!rows[i].host | rows[i].dev1, !rows[i].host});
            chk("sp_oe", poe[29], rows[i].dev1);
            chk("dseen", dseen, rows[i].host & !rows[i].dev1);
            sfv <= 1'b1;
            sfm <= 3'h4;
            @(posedge clk);
            sfv <= 1'b0;
            repeat (3) @(posedge clk);
            chk("setfeat", udma, rows[i].fix ? rows[i].udma : 3'h4);
        end
        {dbsy, act} <= 2'b01;
        repeat (2) @(posedge clk);
        chk("dasp_act", poe[28], 1'b1);
        act <= 1'b0;
        repeat (2) @(posedge clk);
        chk("dasp_idle", poe[28], 1'b0);
        chk("link0", lnk, 1'b0);
        phy <= 1'b1;
        repeat (3) @(posedge clk);
        chk("link1", lnk, 1'b1);
        mode <= 3'h0;
        repeat (4) @(posedge clk);
        chk("frozen", host, 1'b1);
        wb(1'b0, 8'h04, 32'h0);
        chk("strap", q & 32'h3ff, 32'h3aa);
        wb(1'b0, 8'h08, 32'h0);
        chk("stat", q & 32'h760, 32'h460);
        wb(1'b0, 8'h00, 32'h0);
        chk("ctrl", q, 32'h0);
        wb(1'b0, 8'h40, 32'h0);
        chk("unmapped", q, 32'h0);
        ddone <= 1'b1;
        repeat (3) @(posedge clk);
        chk("diag_oe", pooe, 1'b1);
        chk("diag_lvl", poo, 1'b0);
        ddone <= 1'b0;
        cout <= 30'h3fff_ffff;
        dd <= 1'b1;
        wb(1'b1, 8'h00, 32'h1);
        repeat (2) @(posedge clk);
        chk("float", poe, 30'h0);
        wb(1'b1, 8'h00, 32'h0);
        // Device bridge in reverse order; the far side drives pads 5 and 12 high.
        {mode, ms_drv, po_drv, hdrv, hval} <= {3'h2, 2'b01, 30'h08e0_1020, 30'h08e0_1020};
        cout <= 30'h0000_2000;
        do_rst();
        chk("rev_out", {poe[0], pout[0]}, 2'b11);
        chk("rev_in", cin[24], 1'b1);
        chk("rev_oe", pooe, 1'b0);
        chk("cable40", c80, 1'b0);
        chk("ms_out", {msoe, mso}, 2'b10);
        {po_drv, oe, hdrv, hval} <= {2'b00, 30'h08e0_0000, 30'h08e0_0000};
        do_rst();
        chk("oe_strap", poe, 30'h0);
        chk("cable80", c80, 1'b1);
        {oe, pm, por_n} <= 3'b100;
        for (int i = 0; i < 6 && grst !== 1'b1; i++) @(posedge clk);
        chk("por", grst, 1'b1);
        repeat (2) @(posedge clk);
        chk("por_oe", poe, 30'h0);
        por_n <= 1'b1;
        repeat (14) @(posedge clk);
        chk("dd_oe", poe[15:0], 16'hffff);
        lpr <= 1'b1;
        pmd <= 1'b1;
        @(posedge clk);
        {lpr, pmd} <= 2'b00;
        @(posedge clk);
        chk("pm_off", {pacc, slq, prej}, 3'b001);
        repeat (5) @(posedge clk);
        {mode, pm} <= {3'h6, 1'b1};
        do_rst();
        {pmd, lpr} <= 2'b11;
        @(posedge clk);
        {pmd, lpr} <= 2'b00;
        for (int i = 0; i < 8 && slq !== 1'b1; i++) @(posedge clk);
        chk("slumber", slq, 1'b1);
        chk("pm_acc", pacc, 1'b1);
        pio <= 3'h3;
        repeat (2) @(posedge clk);
        chk("iordy_p3", poe[26], 1'b1);
        {pio, uda} <= {3'h2, 1'b1};
        repeat (2) @(posedge clk);
        chk("iordy_dma", poe[26], 1'b1);
        uda <= 1'b0;
        repeat (2) @(posedge clk);
        chk("iordy_p2", poe[26], 1'b0);
        test_done();
    end
endmodule
`default_nettype wire
